// >>> hdl/smrc_cfg.svh
`ifndef SMRC_CFG_SVH
`define SMRC_CFG_SVH
`define SMRC_LONG_RECOVERY_CYCLES 4096
`define SMRC_SHORT_RECOVERY_CYCLES 32
`define SMRC_CNT_WIDTH 13
`endif

// >>> hdl/smrc_pkg.sv
package smrc_pkg;
  typedef enum logic [3:0] {
    SMRC_RUN = 4'b0001,
    SMRC_STOP = 4'b0010,
    SMRC_RECOVER = 4'b0100,
    SMRC_STACK = 4'b1000
  } smrc_state_t;
endpackage : smrc_pkg

// >>> hdl/smrc_sync.sv
`timescale 1ns/1ps
module smrc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = clk_en_i ? async_i : meta_r;
    sync_nxt = clk_en_i ? meta_r : sync_r;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule : smrc_sync

// >>> hdl/smrc_ctrl.sv
`timescale 1ns/1ps
`include "smrc_cfg.svh"
// Functional notes
// - Stop entry clears counter, disables clocks
// - Module interrupt request leaves stop
// - Stacking starts after full recovery delay
// - Reset also ends stop mode
// - Gate base and crystal clock outputs
// - Delay 4096 cycles, or 32 if short
// - Break logic held inactive during stop
// - Stop leaves break registers unchanged
// - Exit event is reset OR interrupt OR break
module smrc_ctrl #(
  parameter int LONG_CYCLES = `SMRC_LONG_RECOVERY_CYCLES,
  parameter int SHORT_CYCLES = `SMRC_SHORT_RECOVERY_CYCLES,
  parameter int CNT_W = `SMRC_CNT_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic stop_req_i,
  input wire logic short_stop_recovery_select_i,
  input wire logic module_irq_i,
  input wire logic break_irq_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic stack_done_i,
  output logic base_clock_en_o,
  output logic crystal_clock_en_o,
  output logic break_logic_en_o,
  output logic break_regs_hold_o,
  output logic low_power_exit_event_o,
  output logic stack_start_o,
  output logic in_stop_o,
  output smrc_pkg::smrc_state_t state_o
);
  import smrc_pkg::*;

  logic [1:0] async_sync;
  logic irq_s;
  logic rst_pin_n_s;
  smrc_state_t state_r;
  smrc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic short_r;
  logic short_nxt;
  logic clk_on_r;
  logic clk_on_nxt;
  logic stack_r;
  logic stack_nxt;
  logic [CNT_W-1:0] target;
  logic exit_event;

  // Interrupt and reset pin come from other domains
  smrc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .async_i({module_irq_i, ext_reset_pin_n_i}),
    .sync_o(async_sync)
  );
  assign irq_s = async_sync[1];
  assign rst_pin_n_s = async_sync[0];

  assign exit_event = !rst_pin_n_s || irq_s || break_irq_i;
  // Last count value before clocks return; count starts at zero
  assign target = short_r ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    short_nxt = short_r;
    clk_on_nxt = clk_on_r;
    // Pulse held while frozen so a low enable cannot swallow it
    stack_nxt = stack_r;
    if (clk_en_i) begin
      stack_nxt = 1'b0;
      unique case (state_r)
        SMRC_RUN: begin
          if (stop_req_i) begin
            state_nxt = SMRC_STOP;
            cnt_nxt = '0;
            clk_on_nxt = 1'b0;
            // Select latched at entry so a mid-stop change cannot shorten it
            short_nxt = short_stop_recovery_select_i;
          end
        end
        SMRC_STOP: begin
          cnt_nxt = '0;
          if (!rst_pin_n_s) begin
            state_nxt = SMRC_RUN;
            clk_on_nxt = 1'b1;
          end else if (exit_event) begin
            state_nxt = SMRC_RECOVER;
          end
        end
        SMRC_RECOVER: begin
          if (!rst_pin_n_s) begin
            state_nxt = SMRC_RUN;
            clk_on_nxt = 1'b1;
          end else if (cnt_r == target) begin
            state_nxt = SMRC_STACK;
            clk_on_nxt = 1'b1;
            stack_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
        SMRC_STACK: begin
          if (stack_done_i || !rst_pin_n_s) begin
            state_nxt = SMRC_RUN;
          end
        end
        default: begin
          state_nxt = SMRC_RUN;
          clk_on_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= SMRC_RUN;
      cnt_r <= '0;
      short_r <= 1'b0;
      clk_on_r <= 1'b1;
      stack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      short_r <= short_nxt;
      clk_on_r <= clk_on_nxt;
      stack_r <= stack_nxt;
    end
  end

  assign base_clock_en_o = clk_on_r;
  assign crystal_clock_en_o = clk_on_r;
  // Break logic frozen, not reset, so its registers survive stop
  assign break_logic_en_o = clk_on_r;
  assign break_regs_hold_o = !clk_on_r;
  assign low_power_exit_event_o = exit_event;
  assign stack_start_o = stack_r;
  assign in_stop_o = (state_r == SMRC_STOP) || (state_r == SMRC_RECOVER);
  assign state_o = state_r;
endmodule : smrc_ctrl

// >>> sim/smrc_ctrl_properties.sv
`timescale 1ns/1ps
module smrc_ctrl_properties #(
  parameter int LONG_CYCLES = 4096,
  parameter int SHORT_CYCLES = 32
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic stop_req_i,
  input wire logic break_irq_i,
  input wire logic base_clock_en_o,
  input wire logic break_logic_en_o,
  input wire logic low_power_exit_event_o,
  input wire logic stack_start_o,
  input wire logic in_stop_o,
  input wire smrc_pkg::smrc_state_t state_o
);
  import smrc_pkg::*;
  int cnt_r = 0;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clk_sys_i) cnt_r <= (state_o == SMRC_RECOVER) ? cnt_r + 1 : 0;
  property p_entry; state_o == SMRC_RUN && stop_req_i |=> !base_clock_en_o; endproperty
  a_entry: assert property (p_entry) else $error("clock on after stop");
  property p_gate; in_stop_o |-> !base_clock_en_o; endproperty
  a_gate: assert property (p_gate) else $error("clock on in stop");
  property p_exit; state_o == SMRC_STOP && low_power_exit_event_o |=> state_o != SMRC_STOP; endproperty
  a_exit: assert property (p_exit) else $error("stop not left");
  property p_event; break_irq_i |-> low_power_exit_event_o; endproperty
  a_event: assert property (p_event) else $error("no exit event");
  property p_delay; stack_start_o |-> cnt_r == SHORT_CYCLES || cnt_r == LONG_CYCLES; endproperty
  a_delay: assert property (p_delay) else $error("bad recovery");
  property p_recov; state_o == SMRC_RECOVER |-> !base_clock_en_o; endproperty
  a_recov: assert property (p_recov) else $error("early clock");
  property p_brk; in_stop_o |-> !break_logic_en_o; endproperty
  a_brk: assert property (p_brk) else $error("break active");
  property p_pulse; stack_start_o |=> !stack_start_o && base_clock_en_o; endproperty
  a_pulse: assert property (p_pulse) else $error("bad stack start");
  cover property (stack_start_o && cnt_r == SHORT_CYCLES);
  cover property (stack_start_o && cnt_r == LONG_CYCLES);
  cover property (in_stop_o ##1 state_o == SMRC_RUN);
endmodule : smrc_ctrl_properties
bind smrc_ctrl smrc_ctrl_properties #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_props (.*);

// >>> sim/smrc_cpu_model.sv
`timescale 1ns/1ps
module smrc_cpu_model (
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire logic [3:0] lag_i,
  output logic done_o
);
  int left_r = -1;
  logic done_r = 1'h0;
  assign done_o = done_r;
  // Stacking length varies, as a real core's does
  always @(posedge clk_sys_i) begin
    done_r <= left_r == 0;
    left_r <= start_i ? int'(lag_i) : left_r - int'(left_r >= 0);
  end
endmodule : smrc_cpu_model

// >>> sim/stop_mode_recovery_control_test.sv
`timescale 1ns/1ps
module stop_mode_recovery_control_test;
  import smrc_pkg::*;
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1, stop_req_i = 1'h0, short_stop_recovery_select_i = 1'h0;
  logic module_irq_i = 1'h0, break_irq_i = 1'h0, ext_reset_pin_n_i = 1'h1, stack_done_i;
  logic base_clock_en_o, crystal_clock_en_o, break_logic_en_o, break_regs_hold_o, low_power_exit_event_o;
  logic stack_start_o, in_stop_o;
  smrc_state_t state_o;
  logic [3:0] lag = 4'h0;
  int seed = 27, bad_count = 0, compares = 0, rc = 0;
  int q[$];
  initial forever #4 clk_sys_i = ~clk_sys_i;
  smrc_ctrl #(.LONG_CYCLES(64), .SHORT_CYCLES(4)) dut (.*);
  smrc_cpu_model cpu (.clk_sys_i, .start_i(stack_start_o), .lag_i(lag), .done_o(stack_done_i));
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
    compares++;
    if (e !== s) begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  always @(negedge clk_sys_i) begin
    if (state_o == SMRC_RECOVER) rc++;
    if (stack_start_o === 1'h1) begin
      chk("recovery", 13'(q.pop_front()), 13'(rc));
      rc = 0;
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys_i);
    reset_n_i = 1'h1;
    for (int i = 0; i < 6; i++) begin
      repeat (4) @(negedge clk_sys_i);
      short_stop_recovery_select_i = i[0];
      lag = 4'($random(seed));
      stop_req_i = 1'h1;
      @(negedge clk_sys_i);
      stop_req_i = 1'h0;
      chk("stopped", 13'h0, {base_clock_en_o, crystal_clock_en_o, break_logic_en_o, ~break_regs_hold_o});
      // Flipped after entry: must not alter the running delay
      short_stop_recovery_select_i = ~i[0];
      if (i % 3 == 2) ext_reset_pin_n_i = 1'h0;
      else begin
        q.push_back(i[0] ? 4 : 64);
        if (i % 3 == 1) module_irq_i = 1'h1;
        else break_irq_i = 1'h1;
      end
      for (int k = 0; k < 100 && in_stop_o; k++) @(negedge clk_sys_i);
      {module_irq_i, break_irq_i, ext_reset_pin_n_i} = 3'h1;
      for (int k = 0; k < 30 && state_o != SMRC_RUN; k++) @(negedge clk_sys_i);
      chk("running", 13'h7, {base_clock_en_o, crystal_clock_en_o, break_logic_en_o});
    end
    wrap_up();
  end
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
endmodule : stop_mode_recovery_control_test
